// File: flash_host.sv
/*
 * Host-side controller that drives an asynchronous parallel NOR flash by
 * its pins: selects, output enable, write strobe, reset and width select.
 * Assumes the flash pins are synchronous to clk and that the busy pin is
 * pulled up outside; the data bus is resolved by the testbench from dq_oe_n and oe_n.
 */
// Functional notes
// [R1] device selected by three-select truth table
// [R2] single chip: second and third selects low
// [R3] read drives data only with oe low
// [R4] write strobe low, oe high: command word
// [R5] never assert oe and write together
// [R6] byte mode uses low eight data lines
// [R7] low program supply refuses alterations
// [R8] busy low while write engine runs
// [R9] busy released when idle or suspended
// [R10] busy low pulse at least 500 ns
// [R11] reset low 25 us in op, 100 ns read
// [R12] device enters reset within 100 ns
// [R13] reset held 60 us after power valid
// [R14] await recovery after busy and reset high
// [R15] space erase suspend after erase start
// [R16] buffer program timeouts 2000/3600 us
// [R17] engine runs algorithms autonomously
// [R18] wait busy release before new command; host waits only on OP_WAIT and in recovery after reset, req_ready ignores busy
`timescale 1ns/1ps
module flash_host
   import flash_host_pkg::*;
#(
   parameter int POWERUP_CYC   = POWERUP_HOLD_CYC,
   parameter int RST_OP_CYC    = RESET_OP_LOW_CYC,
   parameter int TMO128_CYC    = BUF128_TIMEOUT_CYC,
   parameter int TMO256_CYC    = BUF256_TIMEOUT_CYC,
   parameter int ACCESS_CYC    = 4,
   parameter int RECOVER_CYC   = 6
)(
   input  wire logic        clk,
   input  wire logic        reset_n,
   // user side
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [1:0]  req_op,
   input  wire logic [22:0] req_addr,
   input  wire logic [15:0] req_wdata,
   input  wire logic        req_byte_mode,
   input  wire logic        req_big_buf,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   output logic             rsp_timeout,
   // flash pins
   output logic [22:0]      flash_addr,
   output logic             select_line_first,
   output logic             select_line_second,
   output logic             select_line_third,
   output logic             oe_n,
   output logic             we_n,
   output logic             reset_powerdown_n,
   output logic             byte_n,
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq_out,
   output logic             dq_oe_n,
   input  wire logic        busy_indicator_pin
);
   typedef enum {S_PWRUP, S_IDLE, S_RD, S_WR, S_WHOLD, S_RST, S_RECOV,
                 S_WAIT} state_e;

   state_e            state_ff, nxt_state;
   logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
   logic [22:0]       addr_ff, nxt_addr;
   logic [15:0]       wdata_ff, nxt_wdata;
   logic [15:0]       rdata_ff, nxt_rdata;
   logic              byte_ff, nxt_byte;
   logic              busy_seen_ff, nxt_busy_seen;
   logic              tmo_ff, nxt_tmo;
   logic              rsp_ff, nxt_rsp;
   logic [CNT_W-1:0]  gap_ff, nxt_gap;
   logic              write_held;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      return CNT_W'(n);
   endfunction

   // single-chip wiring: only the first select toggles
   assign select_line_second = 1'b0;                          // [R2]
   assign select_line_third  = 1'b0;                          // [R2]
   always_comb begin
      // with second and third low, first low selects the device
      select_line_first = !(state_ff == S_RD || state_ff == S_WR); // [R1]
      oe_n    = (state_ff != S_RD);                           // [R3] [R5]
      we_n    = (state_ff != S_WR) || (state_ff == S_RD);     // [R4] [R5]
      dq_oe_n = !(state_ff == S_WR || state_ff == S_WHOLD);   // [R4]
      reset_powerdown_n = !(state_ff == S_PWRUP || state_ff == S_RST);
   end

   // an erase suspend issued too soon after its erase can make that erase
   // fail, so every command write waits out the gap left by the last one
   assign write_held  = (gap_ff != '0) && (req_op == OP_WRITE); // [R15]
   assign req_ready   = (state_ff == S_IDLE) && !write_held;
   assign flash_addr  = addr_ff;
   assign dq_out      = wdata_ff;
   assign byte_n      = byte_ff;
   assign rsp_valid   = rsp_ff;
   assign rsp_rdata   = rdata_ff;
   assign rsp_timeout = tmo_ff;

   always_comb begin
      nxt_state     = state_ff;
      nxt_cnt       = cnt_ff;
      nxt_addr      = addr_ff;
      nxt_wdata     = wdata_ff;
      nxt_rdata     = rdata_ff;
      nxt_byte      = byte_ff;
      nxt_busy_seen = busy_seen_ff;
      nxt_tmo       = 1'b0;
      nxt_rsp       = 1'b0;
      nxt_gap       = (gap_ff != '0) ? gap_ff - 1'b1 : gap_ff;
      case (state_ff)
         S_PWRUP: begin
            if (cnt_ff >= cyc(POWERUP_CYC - 1)) begin         // [R13]
               nxt_state = S_RECOV;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         S_IDLE: begin
            nxt_cnt = '0;
            if (req_valid && !write_held) begin
               nxt_addr  = req_addr;
               nxt_wdata = req_byte_mode ? (req_wdata & BYTE_MASK)
                                         : req_wdata;         // [R6]
               nxt_byte  = !req_byte_mode;                    // [R6]
               if (req_op == OP_READ) begin
                  nxt_state = S_RD;
               end else if (req_op == OP_WRITE) begin
                  nxt_state = S_WR;
                  nxt_gap   = cyc(SUSPEND_GAP_CYC);           // [R15]
               end else if (req_op == OP_RESET) begin
                  nxt_state = S_RST;
               end else begin
                  nxt_busy_seen = 1'b0;
                  nxt_state     = S_WAIT;
               end
            end
         end
         S_RD: begin
            if (cnt_ff >= cyc(ACCESS_CYC - 1)) begin
               nxt_rdata = byte_ff ? dq_in : (dq_in & BYTE_MASK); // [R6]
               nxt_rsp   = 1'b1;
               nxt_state = S_IDLE;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         S_WR: begin
            // 80 ns strobe covers the 60 ns write pulse minimum
            if (cnt_ff >= cyc(WR_PULSE_CYC - 1)) begin
               nxt_state = S_WHOLD;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         S_WHOLD: begin
            nxt_rsp   = 1'b1;
            nxt_state = S_IDLE;
         end
         S_RST: begin
            // always uses the longer hold, safe for a running operation
            if (cnt_ff >= cyc(RST_OP_CYC - 1)) begin          // [R11]
               nxt_state = S_RECOV;
               nxt_cnt   = '0;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         S_RECOV: begin
            // count restarts while busy is low: later of busy and reset
            if (!busy_indicator_pin) begin                    // [R14]
               nxt_cnt = '0;
            end else if (cnt_ff >= cyc(RECOVER_CYC - 1)) begin
               nxt_rsp   = 1'b1;
               nxt_state = S_IDLE;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         S_WAIT: begin
            // busy may fall late, so a pin already high is not trusted
            if (!busy_indicator_pin) begin                    // [R8]
               nxt_busy_seen = 1'b1;
            end
            if (busy_seen_ff && busy_indicator_pin) begin     // [R18] [R9]
               nxt_rsp   = 1'b1;
               nxt_state = S_IDLE;
            end else if (cnt_ff >= cyc(byte_ff && req_big_buf ?
                                       TMO256_CYC : TMO128_CYC)) begin // [R16]
               nxt_tmo   = 1'b1;
               nxt_rsp   = 1'b1;
               nxt_state = S_IDLE;
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_ff     <= S_PWRUP;
         cnt_ff       <= '0;
         addr_ff      <= '0;
         wdata_ff     <= DATA_ZERO;
         rdata_ff     <= DATA_ZERO;
         byte_ff      <= 1'b1;
         busy_seen_ff <= 1'b0;
         tmo_ff       <= 1'b0;
         rsp_ff       <= 1'b0;
         gap_ff       <= '0;
      end else begin
         state_ff     <= nxt_state;
         cnt_ff       <= nxt_cnt;
         addr_ff      <= nxt_addr;
         wdata_ff     <= nxt_wdata;
         rdata_ff     <= nxt_rdata;
         byte_ff      <= nxt_byte;
         busy_seen_ff <= nxt_busy_seen;
         tmo_ff       <= nxt_tmo;
         rsp_ff       <= nxt_rsp;
         gap_ff       <= nxt_gap;
      end
   end
endmodule

// File: flash_host_checker.sv
/* Assertions on the pins of flash_host.
   Assumes it is bound to flash_host from the testbench top. */
`timescale 1ns/1ps
module flash_host_checker (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        req_valid,
   input wire logic        req_ready,
   input wire logic [1:0]  req_op,
   input wire logic        rsp_valid,
   input wire logic [15:0] rsp_rdata,
   input wire logic        select_line_first,
   input wire logic        select_line_second,
   input wire logic        select_line_third,
   input wire logic        oe_n,
   input wire logic        we_n,
   input wire logic        reset_powerdown_n,
   input wire logic        byte_n,
   input wire logic        dq_oe_n,
   input wire logic        busy_indicator_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_strobe_excl: assert property (oe_n || we_n)
      else $error("oe and we low together");
   a_single_chip: assert property (
      !select_line_second && !select_line_third)
      else $error("upper selects not low");
   a_read_select: assert property (
      !oe_n |-> !select_line_first && reset_powerdown_n)
      else $error("read without select");
   a_bus_contend: assert property (!dq_oe_n |-> oe_n)
      else $error("host drives during read");
   a_write_cycle: assert property (
      $fell(we_n) |-> oe_n && !dq_oe_n && !select_line_first
                      && busy_indicator_pin)
      else $error("bad write strobe");
   a_read_walk: assert property (
      req_valid && req_ready && req_op == 2'h0
      |=> !oe_n [*4] ##1 rsp_valid)
      else $error("read timing wrong");
   a_power_hold: assert property (
      $rose(reset_n) |=> !reset_powerdown_n [*8])
      else $error("power-up hold short");
   a_reset_hold: assert property (
      $fell(reset_powerdown_n) |=> !reset_powerdown_n [*8])
      else $error("reset pulse short");
   a_byte_mask: assert property (
      rsp_valid && !byte_n && !$past(oe_n) |-> rsp_rdata[15:8] == 8'h00)
      else $error("byte read not masked");
   c_byte_read: cover property (rsp_valid && !byte_n);
   c_busy_seen: cover property ($fell(busy_indicator_pin));
   c_reset_op: cover property ($fell(reset_powerdown_n));
endmodule

// File: flash_host_pkg.sv
/*
 * Constants shared by the parallel flash host controller: timing figures,
 * derived cycle counts and operation codes of the user-side port.
 * Assumes a single 25 MHz system clock.
 */
package flash_host_pkg;
   localparam int CLK_MHZ            = 25;
   localparam int CLK_NS             = 40;
   // figures as printed, each in its own unit
   localparam int RESET_OP_LOW_US    = 25;
   localparam int RESET_READ_LOW_NS  = 100;
   localparam int POWERUP_HOLD_US    = 60;
   localparam int BUF128_TIMEOUT_US  = 2000;
   localparam int BUF256_TIMEOUT_US  = 3600;
   localparam int BUF128_WORDS       = 128;
   localparam int BUF256_WORDS       = 256;
   // least times round up
   localparam int RESET_OP_LOW_CYC   = RESET_OP_LOW_US * CLK_MHZ;
   localparam int RESET_READ_LOW_CYC =
      (RESET_READ_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWERUP_HOLD_CYC   = POWERUP_HOLD_US * CLK_MHZ;
   // timeouts are longest waits: plain products already whole
   localparam int BUF128_TIMEOUT_CYC = BUF128_TIMEOUT_US * CLK_MHZ;
   localparam int BUF256_TIMEOUT_CYC = BUF256_TIMEOUT_US * CLK_MHZ;

   localparam int CNT_W = 24;

   // write strobe length in cycles
   localparam int WR_PULSE_CYC       = 2;
   // no erase-to-suspend spacing is fixed: plain default, in cycles
   localparam int SUSPEND_GAP_CYC    = 16;

   localparam logic [1:0] OP_READ  = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_RESET = 2'h2;
   localparam logic [1:0] OP_WAIT  = 2'h3;

   localparam logic [15:0] DATA_ZERO = 16'h0000;
   localparam logic [15:0] BYTE_MASK = 16'h00FF;
endpackage

// File: flash_model.sv
/* Behavioural flash device facing flash_host.
   Assumes pins move just after clk rises; busy pin driven high here when not busy. */
`timescale 1ns/1ps
module flash_model #(parameter int BUSY_CYC = 20) (
   input  wire logic        clk,
   input  wire logic        program_enable_supply_high,
   input  wire logic [22:0] addr,
   input  wire logic        sel0,
   input  wire logic        sel1,
   input  wire logic        sel2,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        rp_n,
   input  wire logic        byte_n,
   input  wire logic [15:0] host_dq,
   input  wire logic        host_oe_n,
   output logic [15:0]      dq,
   output logic             busy_pin,
   output logic [15:0]      last_cmd
);
   logic        selected;
   logic        we_q = 1'b1;
   logic [15:0] hold = 16'h0000;
   int          busy_cnt = 0;
   assign selected = (~sel2 & ~sel1 & ~sel0)
                   | (sel2 & ~(sel1 & sel0));
   assign busy_pin = (busy_cnt > 0 && rp_n) ? 1'b0 : 1'b1;
   always_comb begin
      if (!host_oe_n)
         dq = host_dq;
      else if (rp_n && selected && !oe_n)
         dq = byte_n ? {addr[7:0], ~addr[7:0]}
                     : {~hold[15:8], addr[7:0]};
      else
         dq = ~hold; // released bus keeps toggling, never a stale value
   end
   always_ff @(posedge clk) begin
      hold <= dq;
      we_q <= we_n;
      if (!rp_n)
         busy_cnt <= 0;
      else if (busy_cnt > 0)
         busy_cnt <= busy_cnt - 1;
      else if (!we_n && we_q && selected && oe_n) begin
         last_cmd <= host_dq;
         if (program_enable_supply_high)
            busy_cnt <= BUSY_CYC;
      end
   end
endmodule

// File: testbench.sv
/* Self-checking bench for flash_host with a flash model.
   Assumes shortened power-up, reset and timeout counts. */
`timescale 1ns/1ps
module testbench;
   import flash_host_pkg::*;
   logic        clk = 0, reset_n = 0, req_valid = 0, req_byte_mode = 0;
   logic        req_big_buf = 0, program_enable_supply_high = 1;
   logic [1:0]  req_op = 2'h0;
   logic [22:0] req_addr = 23'h0, flash_addr;
   logic [15:0] req_wdata = 16'h0, got_data, dq_in, dq_out, last_cmd;
   logic [15:0] rsp_rdata;
   logic        req_ready, rsp_valid, rsp_timeout, got_tmo, oe_n, we_n;
   logic        select_line_first, select_line_second, select_line_third;
   logic        reset_powerdown_n, byte_n, dq_oe_n, busy_indicator_pin;
   int          num_errors = 0, compares = 0, cycles = 0;
   always #20 clk = ~clk;
   flash_host #(.POWERUP_CYC(20), .RST_OP_CYC(10), .TMO128_CYC(80),
      .TMO256_CYC(80)) u_flash_host (.clk, .reset_n, .req_valid, .req_ready,
      .req_op, .req_addr, .req_wdata, .req_byte_mode, .req_big_buf,
      .rsp_valid, .rsp_rdata, .rsp_timeout, .flash_addr, .select_line_first,
      .select_line_second, .select_line_third, .oe_n, .we_n,
      .reset_powerdown_n, .byte_n, .dq_in, .dq_out, .dq_oe_n,
      .busy_indicator_pin);
   // busy outlasts the reset walk, so only an aborted engine reads high
   flash_model #(.BUSY_CYC(40)) u_flash_model (.clk, .program_enable_supply_high,
      .addr(flash_addr),
      .sel0(select_line_first), .sel1(select_line_second),
      .sel2(select_line_third), .oe_n, .we_n, .rp_n(reset_powerdown_n),
      .byte_n, .host_dq(dq_out), .host_oe_n(dq_oe_n), .dq(dq_in),
      .busy_pin(busy_indicator_pin), .last_cmd);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic req(input logic [1:0] op, input logic [22:0] a,
                      input logic [15:0] d, input logic bm);
      int n = 0;
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      req_byte_mode <= bm;
      req_valid <= 1'b1;
      do @(posedge clk); while (req_ready !== 1'b1 && n++ < 400);
      req_valid <= 1'b0;
      do @(posedge clk); while (rsp_valid !== 1'b1 && n++ < 400);
      got_data = rsp_rdata;
      got_tmo = rsp_timeout;
   endtask
   task automatic t_power_up;
      int n = 0;
      while (rsp_valid !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk(16'(n >= 21), 16'h0001);
   endtask
   task automatic t_read;
      req(OP_READ, 23'h0000A5, 16'h0, 1'b0);
      chk(got_data, 16'hA55A);
      req(OP_READ, 23'h0000A5, 16'h0, 1'b1);
      chk(got_data, 16'h00A5);
   endtask
   task automatic t_write_busy;
      req(OP_WRITE, 23'h000010, 16'h00E8, 1'b0);
      chk(last_cmd, 16'h00E8);
      req(OP_WAIT, 23'h0, 16'h0, 1'b0);
      chk(16'(got_tmo), 16'h0000);
      req(OP_WRITE, 23'h000010, 16'h1234, 1'b1);
      chk(last_cmd, 16'h0034);
      req(OP_WAIT, 23'h0, 16'h0, 1'b0);
   endtask
   // engine must stay idle, so the wait can only end by timing out;
   // back-to-back writes must still keep the suspend spacing
   task automatic t_lockout;
      time t0;
      program_enable_supply_high <= 1'b0;
      req_big_buf <= 1'b1;
      req(OP_WRITE, 23'h000020, 16'h0040, 1'b0);
      t0 = $time;
      req(OP_WRITE, 23'h000024, 16'h00D0, 1'b0);
      chk(16'(($time - t0) / CLK_NS >= SUSPEND_GAP_CYC), 16'h0001);
      req(OP_WAIT, 23'h0, 16'h0, 1'b0);
      chk(16'(got_tmo), 16'h0001);
      program_enable_supply_high <= 1'b1;
   endtask
   task automatic t_reset_op;
      req(OP_WRITE, 23'h000030, 16'h0040, 1'b0);
      req(OP_RESET, 23'h0, 16'h0, 1'b0);
      chk(16'(busy_indicator_pin), 16'h0001);
      req(OP_READ, 23'h00003C, 16'h0, 1'b0);
      chk(got_data, 16'h3CC3);
   endtask
   task automatic final_report;
      $display("num_errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_power_up();
      t_read();
      t_write_busy();
      t_lockout();
      t_reset_op();
      final_report();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end
endmodule
bind flash_host flash_host_checker u_flash_host_checker (.clk, .reset_n,
   .req_valid, .req_ready, .req_op, .rsp_valid, .rsp_rdata,
   .select_line_first, .select_line_second, .select_line_third, .oe_n,
   .we_n, .reset_powerdown_n, .byte_n, .dq_oe_n, .busy_indicator_pin);
